/* File: hdl/rtd_pkg.sv */
// Purpose: Constants and helpers for the reserved encoding trap decoder
// Assumes: 32-bit instruction words, APB register access
// Notes:   Opcode sets are 64-bit masks indexed by the primary opcode

package rtd_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] RTD_CFG_OFS = 8'h00;
  localparam logic [7:0] RTD_STATUS_OFS = 8'h04;
  localparam int RTD_CFG_REL_LSB = 0;
  localparam int RTD_CFG_DBG_BIT = 3;
  localparam int RTD_CFG_EXT_BIT = 4;
  localparam int RTD_CFG_CUST_BIT = 5;
  localparam int RTD_CFG_FRM_BIT = 6;
  localparam int RTD_CFG_CP2_BIT = 7;
  localparam int RTD_CFG_CU_LSB = 8;
  localparam int RTD_CFG_M64_BIT = 12;
  localparam int RTD_STAT_CAUSE_LSB = 0;
  localparam int RTD_STAT_CNT_LSB = 16;
  localparam logic [31:0] RTD_CFG_RST = 32'h0000_0306;

  // ----------------------------------------
  // Releases and encodings
  // ----------------------------------------
  localparam logic [2:0] RTD_REL_2 = 3'h2;
  localparam logic [2:0] RTD_REL_6 = 3'h6;
  localparam logic [5:0] RTD_OP_SPECIAL = 6'h00;
  localparam logic [5:0] RTD_OP_COP0 = 6'h10;
  localparam logic [5:0] RTD_OP_COP1 = 6'h11;
  localparam logic [5:0] RTD_OP_COP2 = 6'h12;
  localparam logic [5:0] RTD_OP_COP1X = 6'h13;
  localparam logic [5:0] RTD_OP_USER_GROUP = 6'h1C;
  localparam logic [5:0] RTD_OP_EXT = 6'h1E;
  localparam logic [5:0] RTD_OP_SPECIAL3 = 6'h1F;
  localparam logic [5:0] RTD_OP_PCREL = 6'h3B;
  localparam logic [5:0] RTD_FN_DEBUG = 6'h0E;
  localparam logic [63:0] RTD_CP1_MEM_MASK = 64'h2222_0000_0000_0000;
  localparam logic [63:0] RTD_CP2_MEM_MASK = 64'h4444_0000_0000_0000;
  localparam logic [63:0] RTD_REMOVED_LEGACY_MASK = 64'h0000_7444_0C30_0000;
  localparam logic [63:0] RTD_RELOCATED_LEGACY_MASK = 64'h1119_8000_0000_0000;

  typedef enum logic [1:0] {
    RTD_EXC_NONE = 2'h0,
    RTD_EXC_RI = 2'h1,
    RTD_EXC_CPU = 2'h2
  } rtd_cause_t;

  function automatic logic [5:0] rtd_opcode(input logic [31:0] w);
    return w[31:26];
  endfunction

  function automatic logic [5:0] rtd_funct(input logic [31:0] w);
    return w[5:0];
  endfunction

endpackage

/* File: hdl/rtd_dec_if.sv */
// Purpose: Carries word and configuration to the classifier, verdict back
// Assumes: Purely combinational path within one clock
// Notes:   The classifier never sees the bus
`timescale 1ns/100ps

interface rtd_dec_if;
  logic [31:0] word;
  logic [2:0] rel;
  logic dbg_impl;
  logic ext_present;
  logic cust_present;
  logic cp2_present;
  logic m64;
  logic [3:0] cu;
  logic ri_hit;
  logic cpu_hit;
  logic [1:0] ce;

  modport clsf (input word, rel, dbg_impl, ext_present, cust_present,
    cp2_present, m64, cu, output ri_hit, cpu_hit, ce);
  modport core (output word, rel, dbg_impl, ext_present, cust_present,
    cp2_present, m64, cu, input ri_hit, cpu_hit, ce);
endinterface

/* File: hdl/rtd_classify.sv */
// Purpose: Sorts one instruction word into legal, reserved or unusable
// Assumes: Configuration is stable for the cycle
// Notes:   Unusable coprocessor wins over reserved instruction
`timescale 1ns/100ps

module rtd_classify
  import rtd_pkg::*;
(
  rtd_dec_if.clsf d
);

  // ----------------------------------------
  // Classification
  // ----------------------------------------
  always_comb
  begin
    logic [5:0] op;
    logic r6;
    logic r2;
    logic cop_tgt;
    logic ri;
    logic [1:0] num;
    op = rtd_opcode(d.word);
    r6 = (d.rel >= RTD_REL_6);
    r2 = (d.rel >= RTD_REL_2);
    ri = 1'b0;
    cop_tgt = 1'b0;
    num = 2'h0;
    if (op == RTD_OP_COP0)
    begin
      cop_tgt = 1'b1;
    end
    if (op == RTD_OP_COP1 || op == RTD_OP_COP1X || RTD_CP1_MEM_MASK[op])
    begin
      cop_tgt = 1'b1;
      num = 2'h1;
    end
    // Release 6 reuses these slots for new branches
    if (op == RTD_OP_COP2 || (RTD_CP2_MEM_MASK[op] && !r6))
    begin
      cop_tgt = 1'b1;
      num = 2'h2;
      ri = !d.cp2_present;
    end
    if (op == RTD_OP_USER_GROUP)
    begin
      ri = r6 || !d.cust_present;
    end
    if (op == RTD_OP_COP1X)
    begin
      // Width mode is not consulted from release 2 on
      ri = r6 || (!r2 && !d.m64);
    end
    if (r6 && (RTD_REMOVED_LEGACY_MASK[op] || RTD_RELOCATED_LEGACY_MASK[op]))
    begin
      ri = 1'b1;
    end
    if (op == RTD_OP_EXT && !d.ext_present)
    begin
      ri = 1'b1;
    end
    if (op == RTD_OP_SPECIAL3 && !r2)
    begin
      ri = 1'b1;
    end
    if (op == RTD_OP_PCREL && !r6)
    begin
      ri = 1'b1;
    end
    // Single placement only; no alias is decoded
    if (op == RTD_OP_SPECIAL && rtd_funct(d.word) == RTD_FN_DEBUG)
    begin
      ri = !d.dbg_impl;
    end
    d.cpu_hit = cop_tgt && !d.cu[num];
    d.ri_hit = ri && !(cop_tgt && !d.cu[num]);
    d.ce = num;
  end

endmodule // rtd_classify

/* File: hdl/rtd_trap_top.sv */
// Purpose: Legality check of instruction words with trap selection
// Assumes: Instruction inputs come from logic on pclk
// Notes:   Verdict appears one cycle after the word is offered
//
// Notes on behaviour
// - Empty user group or usable coprocessor encodings trap reserved
// - Empty coprocessor encodings with access denied trap unusable
// - Release 6 traps the whole user group; older ones may define it
// - Absent debug instruction traps reserved
// - Present debug instruction decodes at its single assigned encoding only
// - Extension encodings trap reserved when the extension is absent
// - Release 2 encodings run on release 2 up, trap on release 1
// - Release 6 traps removed and relocated legacy encodings
// - Reused removed encodings: coprocessor unusable beats reserved
// - Corrected float ops legal in releases 2 to 5 in any width mode
// - On coprocessor encodings unusable beats reserved
// - Release 6 decodes fully; empty encodings trap reserved
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps

module rtd_trap_top
  import rtd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  output logic res_valid,
  output logic exc_ri,
  output logic exc_cpu,
  output logic [1:0] exc_ce,
  output logic commit_en
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] rel;
    logic dbg;
    logic ext;
    logic cust;
    logic frm;
    logic cp2;
    logic m64;
    logic [3:0] cu;
    logic [31:0] rdata;
    logic slverr;
    logic res_valid;
    logic exc_ri;
    logic exc_cpu;
    logic [1:0] exc_ce;
    logic commit_en;
    logic [15:0] trap_cnt;
    rtd_cause_t last_cause;
  } rtd_state_t;

  localparam rtd_state_t RTD_STATE_RST = '{
    rel: RTD_CFG_RST[RTD_CFG_REL_LSB +: 3],
    dbg: RTD_CFG_RST[RTD_CFG_DBG_BIT],
    ext: RTD_CFG_RST[RTD_CFG_EXT_BIT],
    cust: RTD_CFG_RST[RTD_CFG_CUST_BIT],
    frm: RTD_CFG_RST[RTD_CFG_FRM_BIT],
    cp2: RTD_CFG_RST[RTD_CFG_CP2_BIT],
    m64: RTD_CFG_RST[RTD_CFG_M64_BIT],
    cu: RTD_CFG_RST[RTD_CFG_CU_LSB +: 4],
    rdata: 32'h0000_0000,
    slverr: 1'b0,
    res_valid: 1'b0,
    exc_ri: 1'b0,
    exc_cpu: 1'b0,
    exc_ce: 2'h0,
    commit_en: 1'b0,
    trap_cnt: 16'h0000,
    last_cause: RTD_EXC_NONE
  };

  rtd_state_t s_reg;
  rtd_state_t s_next;
  rtd_dec_if dec ();
  logic setup_ph;
  logic write_acc;
  logic [31:0] cfg_word;
  logic [31:0] stat_word;

  function automatic logic rtd_hit(input logic [7:0] a,
    input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ----------------------------------------
  // Classifier
  // ----------------------------------------
  assign dec.word = instr_word;
  assign dec.rel = s_reg.rel;
  assign dec.dbg_impl = s_reg.dbg;
  assign dec.ext_present = s_reg.ext;
  assign dec.cust_present = s_reg.cust;
  assign dec.cp2_present = s_reg.cp2;
  assign dec.m64 = s_reg.m64;
  assign dec.cu = s_reg.cu;

  rtd_classify u_classify (
    .d (dec.clsf)
  );

  // ----------------------------------------
  // Bus view
  // ----------------------------------------
  // Zero wait states keep the slave trivially deterministic
  assign pready = 1'b1;
  assign setup_ph = psel && !penable;
  assign write_acc = psel && penable && pwrite;

  always_comb
  begin
    cfg_word = 32'h0000_0000;
    cfg_word[RTD_CFG_REL_LSB +: 3] = s_reg.rel;
    cfg_word[RTD_CFG_DBG_BIT] = s_reg.dbg;
    cfg_word[RTD_CFG_EXT_BIT] = s_reg.ext;
    cfg_word[RTD_CFG_CUST_BIT] = s_reg.cust;
    cfg_word[RTD_CFG_FRM_BIT] = s_reg.frm;
    cfg_word[RTD_CFG_CP2_BIT] = s_reg.cp2;
    cfg_word[RTD_CFG_CU_LSB +: 4] = s_reg.cu;
    cfg_word[RTD_CFG_M64_BIT] = s_reg.m64;
    stat_word = 32'h0000_0000;
    stat_word[RTD_STAT_CAUSE_LSB +: 2] = s_reg.last_cause;
    stat_word[RTD_STAT_CNT_LSB +: 16] = s_reg.trap_cnt;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic trap;
    s_next = s_reg;
    trap = instr_valid && (dec.ri_hit || dec.cpu_hit);
    // Read data and error are prepared in the setup phase
    if (setup_ph)
    begin
      s_next.rdata = 32'h0000_0000;
      s_next.slverr = 1'b0;
      if (rtd_hit(paddr, RTD_CFG_OFS))
      begin
        s_next.rdata = pwrite ? 32'h0000_0000 : cfg_word;
      end
      else if (rtd_hit(paddr, RTD_STATUS_OFS))
      begin
        s_next.rdata = pwrite ? 32'h0000_0000 : stat_word;
        s_next.slverr = pwrite;
      end
      else
      begin
        s_next.slverr = 1'b1;
      end
    end
    if (write_acc && rtd_hit(paddr, RTD_CFG_OFS))
    begin
      s_next.rel = pwdata[RTD_CFG_REL_LSB +: 3];
      s_next.dbg = pwdata[RTD_CFG_DBG_BIT];
      s_next.ext = pwdata[RTD_CFG_EXT_BIT];
      s_next.cust = pwdata[RTD_CFG_CUST_BIT];
      s_next.frm = pwdata[RTD_CFG_FRM_BIT];
      s_next.cp2 = pwdata[RTD_CFG_CP2_BIT];
      s_next.cu = pwdata[RTD_CFG_CU_LSB +: 4];
      s_next.m64 = pwdata[RTD_CFG_M64_BIT];
    end
    s_next.res_valid = instr_valid;
    s_next.exc_ri = instr_valid && dec.ri_hit;
    s_next.exc_cpu = instr_valid && dec.cpu_hit;
    s_next.exc_ce = instr_valid ? dec.ce : 2'h0;
    s_next.commit_en = instr_valid && !trap;
    if (trap)
    begin
      s_next.trap_cnt = s_reg.trap_cnt + 16'h0001;
      s_next.last_cause = dec.cpu_hit ? RTD_EXC_CPU : RTD_EXC_RI;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= RTD_STATE_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.rdata;
  assign pslverr = s_reg.slverr;
  assign res_valid = s_reg.res_valid;
  assign exc_ri = s_reg.exc_ri;
  assign exc_cpu = s_reg.exc_cpu;
  assign exc_ce = s_reg.exc_ce;
  assign commit_en = s_reg.commit_en;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [5:0] op_now;
  logic r6_now;
  assign op_now = rtd_opcode(instr_word);
  assign r6_now = (s_reg.rel >= RTD_REL_6);

  sequence s_word(logic [5:0] o);
    instr_valid && op_now == o;
  endsequence

  a_one_cause: assert property (
    res_valid |-> !(exc_ri && exc_cpu) && !((exc_ri || exc_cpu) && commit_en))
    else $error("two causes or commit with trap");

  a_verdict_timing: assert property (
    instr_valid |=> res_valid ##1 (res_valid == $past(instr_valid)))
    else $error("verdict not one cycle after word");

  a_user_r6: assert property (
    s_word(RTD_OP_USER_GROUP) ##0 r6_now |=> exc_ri && !commit_en)
    else $error("user group not trapped on release 6");

  a_user_absent: assert property (
    s_word(RTD_OP_USER_GROUP) ##0 (!r6_now && !s_reg.cust) |=> exc_ri)
    else $error("undefined user group not trapped");

  a_user_defined: assert property (
    s_word(RTD_OP_USER_GROUP) ##0 (!r6_now && s_reg.cust) |=> commit_en)
    else $error("customer instruction refused before release 6");

  a_cop_denied: assert property (
    s_word(RTD_OP_COP2) ##0 !s_reg.cu[2]
      |=> exc_cpu && !exc_ri && exc_ce == 2'h2)
    else $error("denied coprocessor not unusable");

  a_cop_undefined: assert property (
    s_word(RTD_OP_COP2) ##0 (s_reg.cu[2] && !s_reg.cp2) |=> exc_ri)
    else $error("usable empty coprocessor not reserved");

  a_cop_priority: assert property (
    s_word(RTD_OP_COP1) ##0 !s_reg.cu[1] |=> exc_cpu && exc_ce == 2'h1)
    else $error("coprocessor priority lost");

  a_debug_absent: assert property (
    s_word(RTD_OP_SPECIAL) ##0 (rtd_funct(instr_word) == RTD_FN_DEBUG
      && !s_reg.dbg) |=> exc_ri)
    else $error("absent debug instruction not trapped");

  a_debug_exact: assert property (
    s_word(RTD_OP_SPECIAL) ##0 (rtd_funct(instr_word) == RTD_FN_DEBUG
      && s_reg.dbg) |=> commit_en)
    else $error("present debug instruction refused");

  a_ext_absent: assert property (
    s_word(RTD_OP_EXT) ##0 !s_reg.ext |=> exc_ri)
    else $error("absent extension not trapped");

  a_rel2_ops: assert property (
    s_word(RTD_OP_SPECIAL3) |=> exc_ri == ($past(s_reg.rel) < RTD_REL_2))
    else $error("release 2 encoding wrong for release");

  a_legacy_r6: assert property (
    instr_valid && r6_now && (RTD_REMOVED_LEGACY_MASK[op_now]
      || RTD_RELOCATED_LEGACY_MASK[op_now]) |=> exc_ri)
    else $error("legacy encoding not trapped on release 6");

  a_reuse_prio: assert property (
    s_word(RTD_OP_COP1X) ##0 (r6_now && !s_reg.cu[1])
      |=> exc_cpu && !exc_ri)
    else $error("removed coprocessor encoding priority lost");

  a_fr_any: assert property (
    s_word(RTD_OP_COP1X) ##0 (!r6_now && s_reg.rel >= RTD_REL_2
      && s_reg.cu[1]) |=> commit_en)
    else $error("corrected float op refused");

  a_full_decode: assert property (
    s_word(RTD_OP_PCREL) ##0 !r6_now |=> exc_ri)
    else $error("empty encoding not trapped");

  a_one_verdict: assert property (
    res_valid |-> $onehot({exc_ri, exc_cpu, commit_en}))
    else $error("verdict not exactly one of three");

  a_idle_quiet: assert property (
    !res_valid |-> !exc_ri && !exc_cpu && !commit_en && exc_ce == 2'h0)
    else $error("verdict bits without a word");

  a_cop0_denied: assert property (
    s_word(RTD_OP_COP0) ##0 !s_reg.cu[0]
      |=> exc_cpu && exc_ce == 2'h0)
    else $error("denied system coprocessor not unusable");

  a_cop1_mem: assert property (
    instr_valid && RTD_CP1_MEM_MASK[op_now] && !s_reg.cu[1]
      |=> exc_cpu && exc_ce == 2'h1)
    else $error("float load or store priority lost");

  a_trap_count: assert property (
    s_reg.trap_cnt == $past(s_reg.trap_cnt)
      + {15'h0000, (exc_ri || exc_cpu)})
    else $error("trap count not one per trapped word");

  a_last_cause: assert property (
    exc_ri || exc_cpu
      |-> s_reg.last_cause == (exc_cpu ? RTD_EXC_CPU : RTD_EXC_RI))
    else $error("last cause does not match verdict");

  // ----------------------------------------
  // Bus checks
  // ----------------------------------------
  // Read data only moves at a setup cycle, so a late sample still sees it
  a_rdata_hold: assert property (
    !setup_ph |=> $stable(prdata))
    else $error("read data moved outside setup");

  a_bus_error: assert property (
    psel && penable && pwrite && paddr != RTD_CFG_OFS |-> pslverr)
    else $error("write to read-only or unmapped word accepted");

  a_cfg_write: assert property (
    write_acc && paddr == RTD_CFG_OFS
      |=> s_reg.rel == $past(pwdata[RTD_CFG_REL_LSB +: 3])
      && s_reg.cu == $past(pwdata[RTD_CFG_CU_LSB +: 4]))
    else $error("configuration write lost");

  c_user_trap: cover property (s_word(RTD_OP_USER_GROUP) ##1 exc_ri);
  c_cop_unusable: cover property (instr_valid ##1 exc_cpu);
  c_back_to_back: cover property (exc_ri ##1 exc_cpu ##1 commit_en);
  c_cfg_write: cover property (write_acc ##1 instr_valid ##1 exc_ri);
  c_debug_legal: cover property (s_word(RTD_OP_SPECIAL) ##1 commit_en);

endmodule // rtd_trap_top

/* File: test/rtd_fetch_model.sv */
// Purpose: Fetch stage model offering words to the trap decoder
// Assumes: One request pulse from the bench per word
// Notes:   Idle word flips every cycle, never a stale copy
`timescale 1ns/100ps

module rtd_fetch_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic [31:0] req_word,
  output logic instr_valid,
  output logic [31:0] instr_word
);
  // ----------------------------------------
  // Issue stage
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_valid <= 1'b0;
      instr_word <= 32'h0000_0000;
    end
    else
    begin
      instr_valid <= req;
      // Changing idle word so a held copy cannot pass for a new one
      instr_word <= req ? req_word : ~instr_word;
    end
  end
endmodule // rtd_fetch_model

/* File: test/testbench.sv */
// Purpose: Self-checking bench for the trap decoder
// Assumes: Verdict one edge after the fetch model issues a word
// Notes:   Each case writes the configuration, then offers one word
`timescale 1ns/100ps

module testbench
  import rtd_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic req = 1'b0;
  logic [31:0] req_word = 32'h0000_0000;
  logic instr_valid;
  logic [31:0] instr_word;
  logic res_valid;
  logic exc_ri;
  logic exc_cpu;
  logic [1:0] exc_ce;
  logic commit_en;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int compares = 0;
  int traps = 0;

  always #5 pclk = ~pclk;

  rtd_fetch_model u_rtd_fetch_model (.pclk, .presetn, .req, .req_word,
    .instr_valid, .instr_word);

  rtd_trap_top u_rtd_trap_top (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .instr_valid,
    .instr_word, .res_valid, .exc_ri, .exc_cpu, .exc_ce, .commit_en);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out();
    if (err_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chkv(input logic [5:0] exp);
    compares++;
    if ({res_valid, exc_ri, exc_cpu, commit_en, exc_ce} !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: verdict want %h", $time, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Slave decides when it answers; only the watchdog ends a wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input logic [31:0] cfg, input logic [31:0] w,
    input logic [3:0] e);
    apb(1'b1, RTD_CFG_OFS, cfg);
    chk32(32'h0000_0000, {31'h0, er});
    @(posedge pclk);
    req <= 1'b1;
    req_word <= w;
    @(posedge pclk);
    req <= 1'b0;
    @(posedge pclk);
    #1;
    chkv({1'b1, e[3:2] == 2'h1, e[3:2] == 2'h2, e[3:2] == 2'h0, e[1:0]});
    if (e[3:2] != 2'h0)
      traps++;
    @(posedge pclk);
    #1;
    // Verdict is a single-cycle pulse
    chkv(6'h00);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, RTD_CFG_OFS, 32'h0000_0000);
    chk32(32'h0000_0306, rd);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk32(32'h0000_0000, rd);
    chk32(32'h0000_0001, {31'h0, er});
    apb(1'b1, RTD_STATUS_OFS, 32'hFFFF_FFFF);
    chk32(32'h0000_0001, {31'h0, er});
    run(32'h0000_0306, 32'h7000_0000, 4'h4);
    run(32'h0000_0326, 32'h7000_0000, 4'h4);
    run(32'h0000_0322, 32'h7000_0000, 4'h0);
    run(32'h0000_0306, 32'h5000_0000, 4'h4);
    run(32'h0000_0306, 32'hC000_0000, 4'h4);
    run(32'h0000_0306, 32'hEC00_0000, 4'h0);
    run(32'h0000_0306, 32'h0000_000E, 4'h4);
    run(32'h0000_030E, 32'h0000_000E, 4'h0);
    run(32'h0000_030E, 32'h7000_000E, 4'h4);
    run(32'h0000_0306, 32'h7800_0000, 4'h4);
    run(32'h0000_0316, 32'h7800_0000, 4'h0);
    run(32'h0000_0301, 32'h7C00_0000, 4'h4);
    run(32'h0000_0302, 32'h7C00_0000, 4'h0);
    run(32'h0000_0306, 32'h4800_0000, 4'hA);
    run(32'h0000_0706, 32'h4800_0000, 4'h6);
    run(32'h0000_0786, 32'h4800_0000, 4'h2);
    run(32'h0000_0106, 32'h4400_0000, 4'h9);
    run(32'h0000_0206, 32'h4000_0000, 4'h8);
    run(32'h0000_0106, 32'hE400_0000, 4'h9);
    run(32'h0000_0106, 32'h8400_0000, 4'h0);
    run(32'h0000_0302, 32'hEC00_0000, 4'h4);
    run(32'h0000_0106, 32'h4C00_0000, 4'h9);
    run(32'h0000_0302, 32'h4C00_0000, 4'h1);
    run(32'h0000_0342, 32'h4C00_0000, 4'h1);
    run(32'h0000_1301, 32'h4C00_0000, 4'h1);
    run(32'h0000_0306, 32'h4C00_0000, 4'h5);
    run(32'h0000_0301, 32'h4C00_0000, 4'h5);
    apb(1'b0, RTD_STATUS_OFS, 32'h0000_0000);
    chk32({traps[15:0], 14'h0, 2'h1}, rd);
    // Second reset in mid-run: count, cause and configuration return
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, RTD_STATUS_OFS, 32'h0000_0000);
    chk32(32'h0000_0000, rd);
    apb(1'b0, RTD_CFG_OFS, 32'h0000_0000);
    chk32(RTD_CFG_RST, rd);
    close_out();
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial
  begin
    repeat (5000) @(posedge pclk);
    err_count++;
    close_out();
  end
endmodule // testbench
